// File: logic/partition_pkg.sv
// What this block does
// - Partition support per state needs global capability bit and nonzero max field.
// - Per-state capability register shows max partition and group when capability set.
// - Each security state may support partitioning independently and reports it so.
// - Per-state configuration holds identifiers for unit-originated transactions.
// - Client-supplied identifiers are discarded; the block always assigns its own.
// - Translation disabled: use that state's global bypass identifiers.
// - Translation enabled: identifiers come from the stream table entry, descriptor, map or non-secure bypass set.
// - Bypass or stage-2-only entries use the entry identifiers, except translated transactions with check 0.
// - Stage-1-only uses entry ids when control 0, descriptor ids when 1.
// - Nested with control 1 maps 5-bit virtual id through the map.
// - Nested, default substream 0b01, no substream id: treat as stage-2-only.
// - Max partition zero means no map structure; never fetch through its pointer.
// - Translation requests use the same identifiers as an equivalent transaction.
// - Translated transactions with check 0 use non-secure global bypass ids.
// - Translated transactions with check 1 use the entry identifiers.
// - Translated transactions do not use descriptor ids by default.
// - With check 1, an optional PASID may select descriptor identifiers.
// - Secure streams use the secure namespace, non-secure the non-secure one.
// - Namespace flag output is the inverse of the secure stream indicator.
package partition_pkg;
  localparam int PID_W = 16;
  localparam int PMG_W = 8;
  localparam int VPID_W = 5;
  localparam int MAP_DEPTH = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses; each register is one aligned word
  localparam logic [ADDR_W-1:0] REG_CTRL_NS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CTRL_S = 8'h04;
  localparam logic [ADDR_W-1:0] REG_GBP_NS = 8'h08;
  localparam logic [ADDR_W-1:0] REG_GBP_S = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_GM_NS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_GM_S = 8'h14;
  localparam logic [ADDR_W-1:0] REG_CAP_NS = 8'h18;
  localparam logic [ADDR_W-1:0] REG_CAP_S = 8'h1c;
  localparam logic [ADDR_W-1:0] REG_ID3 = 8'h20;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] REG_MAP_BASE = 8'h80;

  // Control register bits
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CHK_BIT = 1;
  localparam int CTRL_PASID_BIT = 2;
  // Identifier fields in the configuration and capability words
  localparam int FLD_PID_LSB = 0;
  localparam int FLD_PMG_LSB = 16;
  localparam int ID3_CAP_BIT = 0;
  // Status register bits
  localparam int STAT_SUP_NS_BIT = 0;
  localparam int STAT_SUP_S_BIT = 1;

  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

  // Stream entry configuration encodings
  localparam logic [2:0] CFG_BYPASS = 3'h1 << 2;
  localparam logic [2:0] CFG_S1 = 3'h5;
  localparam logic [2:0] CFG_S2 = 3'h6;
  localparam logic [2:0] CFG_NEST = 3'h7;
  localparam logic [1:0] DSS_S2_WHEN_NO_SSID = 2'h1;

  typedef enum logic [1:0]
  {
    KIND_NORMAL = 2'b00,
    KIND_ATS_REQ = 2'b01,
    KIND_ATS_XLATED = 2'b10
  } txn_kind_t;

  typedef enum logic [2:0]
  {
    SRC_GBP = 3'b000,
    SRC_STE = 3'b001,
    SRC_CD = 3'b010,
    SRC_MAP = 3'b011,
    SRC_NSGBP = 3'b100
  } id_src_t;

  typedef struct packed
  {
    logic [PID_W-1:0] pid;
    logic [PMG_W-1:0] monitor_group;
  } ids_t;

  // One client transaction with its already fetched configuration
  typedef struct packed
  {
    logic valid;
    logic secure;
    txn_kind_t kind;
    logic [2:0] ste_cfg;
    logic s1_ctrl;
    logic [1:0] s1_dss;
    logic has_ssid;
    logic has_pasid;
    ids_t ste_ids;
    ids_t cd_ids;
    ids_t client_ids;
  } txn_in_t;

  typedef struct packed
  {
    logic valid;
    logic ns_flag;
    ids_t ids;
    logic map_used;
  } txn_out_t;

  typedef struct packed
  {
    logic en;
    logic chk;
    logic pasid_ok;
    ids_t gbp;
    ids_t gm;
  } state_cfg_t;
endpackage

// File: logic/partition_select.sv
`timescale 1ns/1ps
module partition_select
  import partition_pkg::*;
(
  input wire txn_in_t txn,
  input wire state_cfg_t cfg,
  input wire logic vms_ok,
  output id_src_t src
);
  logic [2:0] eff_cfg;
  always_comb
  begin
    eff_cfg = txn.ste_cfg;
    if (txn.ste_cfg == CFG_NEST && txn.s1_dss == DSS_S2_WHEN_NO_SSID && !txn.has_ssid)
    begin
      eff_cfg = CFG_S2;
    end
    if (!cfg.en)
    begin
      src = SRC_GBP;
    end
    else if (txn.kind == KIND_ATS_XLATED)
    begin
      if (!cfg.chk)
      begin
        src = SRC_NSGBP;
      end
      else if (cfg.pasid_ok && txn.has_pasid && eff_cfg == CFG_S1 && txn.s1_ctrl)
      begin
        src = SRC_CD;
      end
      else
      begin
        src = SRC_STE;
      end
    end
    else
    begin
      case (eff_cfg)
        CFG_S1: src = txn.s1_ctrl ? SRC_CD : SRC_STE;
        CFG_NEST: src = (txn.s1_ctrl && vms_ok) ? SRC_MAP : SRC_STE;
        default: src = SRC_STE;
      endcase
    end
  end
endmodule

// File: logic/partition_id_assign.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module partition_id_assign
  import partition_pkg::*;
#(
  parameter int MAX_PID_NS = 16'h00ff,
  parameter int MAX_PMG_NS = 8'h03,
  parameter int MAX_PID_S = 16'h000f,
  parameter int MAX_PMG_S = 8'h01,
  parameter bit CAP_GLOBAL = 1'b1
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire txn_in_t txn,
  output txn_out_t txn_out,
  output logic ns_supported,
  output logic s_supported
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed
  {
    state_cfg_t ns;
    state_cfg_t s;
    logic [MAP_DEPTH-1:0][PID_W-1:0] map;
    logic [DATA_W-1:0] rdata;
    txn_out_t out;
    logic sup_ns;
    logic sup_s;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  localparam ids_t CAP_NS = '{pid: PID_W'(MAX_PID_NS), monitor_group: PMG_W'(MAX_PMG_NS)};
  localparam ids_t CAP_S = '{pid: PID_W'(MAX_PID_S), monitor_group: PMG_W'(MAX_PMG_S)};

  function automatic logic [DATA_W-1:0] pack_ids(input ids_t v);
    logic [DATA_W-1:0] w;
    w = RST_WORD;
    w[FLD_PID_LSB +: PID_W] = v.pid;
    w[FLD_PMG_LSB +: PMG_W] = v.monitor_group;
    return w;
  endfunction

  function automatic ids_t unpack_ids(input logic [DATA_W-1:0] w);
    ids_t v;
    v.pid = w[FLD_PID_LSB +: PID_W];
    v.monitor_group = w[FLD_PMG_LSB +: PMG_W];
    return v;
  endfunction

  function automatic logic [DATA_W-1:0] ctrl_word(input state_cfg_t c);
    logic [DATA_W-1:0] w;
    w = RST_WORD;
    w[CTRL_EN_BIT] = c.en;
    w[CTRL_CHK_BIT] = c.chk;
    w[CTRL_PASID_BIT] = c.pasid_ok;
    return w;
  endfunction

  function automatic logic supported(input ids_t cap);
    return CAP_GLOBAL && (cap.pid != '0 || cap.monitor_group != '0);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  state_cfg_t cur;
  ids_t cap_cur;
  id_src_t src;
  logic vms_ok;

  always_comb
  begin
    cur = txn.secure ? st_ff.s : st_ff.ns;
    cap_cur = txn.secure ? CAP_S : CAP_NS;
    vms_ok = (cap_cur.pid != '0);
  end

  partition_select u_sel
  (
    .txn(txn),
    .cfg(cur),
    .vms_ok(vms_ok),
    .src(src)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rdata = RST_WORD;
    nxt_st.sup_ns = supported(CAP_NS);
    nxt_st.sup_s = supported(CAP_S);

    if (reg_wr)
    begin
      case (reg_addr)
        REG_CTRL_NS:
        begin
          nxt_st.ns.en = reg_wdata[CTRL_EN_BIT];
          nxt_st.ns.chk = reg_wdata[CTRL_CHK_BIT];
          nxt_st.ns.pasid_ok = reg_wdata[CTRL_PASID_BIT];
        end
        REG_CTRL_S:
        begin
          nxt_st.s.en = reg_wdata[CTRL_EN_BIT];
          nxt_st.s.chk = reg_wdata[CTRL_CHK_BIT];
          nxt_st.s.pasid_ok = reg_wdata[CTRL_PASID_BIT];
        end
        REG_GBP_NS: nxt_st.ns.gbp = unpack_ids(reg_wdata);
        REG_GBP_S: nxt_st.s.gbp = unpack_ids(reg_wdata);
        REG_GM_NS: nxt_st.ns.gm = unpack_ids(reg_wdata);
        REG_GM_S: nxt_st.s.gm = unpack_ids(reg_wdata);
        default:
        begin
          // Map entries hold physical ids shared by both states
          if (reg_addr[ADDR_W-1] && reg_addr[1:0] == 2'b00)
          begin
            nxt_st.map[reg_addr[VPID_W+1:2]] = reg_wdata[PID_W-1:0];
          end
        end
      endcase
    end

    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL_NS: nxt_st.rdata = ctrl_word(st_ff.ns);
        REG_CTRL_S: nxt_st.rdata = ctrl_word(st_ff.s);
        REG_GBP_NS: nxt_st.rdata = pack_ids(st_ff.ns.gbp);
        REG_GBP_S: nxt_st.rdata = pack_ids(st_ff.s.gbp);
        REG_GM_NS: nxt_st.rdata = pack_ids(st_ff.ns.gm);
        REG_GM_S: nxt_st.rdata = pack_ids(st_ff.s.gm);
        REG_CAP_NS: nxt_st.rdata = CAP_GLOBAL ? pack_ids(CAP_NS) : RST_WORD;
        REG_CAP_S: nxt_st.rdata = CAP_GLOBAL ? pack_ids(CAP_S) : RST_WORD;
        REG_ID3: nxt_st.rdata[ID3_CAP_BIT] = CAP_GLOBAL;
        REG_STATUS:
        begin
          nxt_st.rdata[STAT_SUP_NS_BIT] = st_ff.sup_ns;
          nxt_st.rdata[STAT_SUP_S_BIT] = st_ff.sup_s;
        end
        default:
        begin
          if (reg_addr[ADDR_W-1] && reg_addr[1:0] == 2'b00)
          begin
            nxt_st.rdata[PID_W-1:0] = st_ff.map[reg_addr[VPID_W+1:2]];
          end
        end
      endcase
    end

    nxt_st.out.valid = txn.valid;
    nxt_st.out.ns_flag = ~txn.secure;
    nxt_st.out.map_used = 1'b0;
    case (src)
      SRC_GBP: nxt_st.out.ids = cur.gbp;
      SRC_NSGBP: nxt_st.out.ids = st_ff.ns.gbp;
      SRC_CD: nxt_st.out.ids = txn.cd_ids;
      SRC_MAP:
      begin
        nxt_st.out.ids.pid = st_ff.map[txn.cd_ids.pid[VPID_W-1:0]];
        nxt_st.out.ids.monitor_group = txn.cd_ids.monitor_group;
        nxt_st.out.map_used = 1'b1;
      end
      default: nxt_st.out.ids = txn.ste_ids;
    endcase
    if (!txn.valid)
    begin
      nxt_st.out.ids = '0;
      nxt_st.out.map_used = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign txn_out = st_ff.out;
  assign ns_supported = st_ff.sup_ns;
  assign s_supported = st_ff.sup_s;
endmodule

// File: tb/client_model.sv
`timescale 1ns/1ps
module client_model
  import partition_pkg::*;
(
  input wire logic clk,
  output txn_in_t txn
);
  logic [7:0] junk_ff = 8'h5a;
  initial txn = '0;
  always @(posedge clk)
  begin
    junk_ff <= junk_ff + 8'h01;
    txn.client_ids <= {junk_ff, ~junk_ff, junk_ff};
  end
  task automatic send(input logic s, input txn_kind_t k, input logic [2:0] c,
    input logic m, input logic [1:0] d, input logic q);
    @(posedge clk);
    txn.valid <= 1'h1;
    txn.secure <= s;
    txn.kind <= k;
    txn.ste_cfg <= c;
    txn.s1_ctrl <= m;
    txn.s1_dss <= d;
    txn.has_ssid <= q;
    txn.has_pasid <= q;
    txn.ste_ids <= 24'h01_0001;
    txn.cd_ids <= 24'h00_0302;
    @(posedge clk);
    txn.valid <= 1'h0;
    // Released fields must not look stable
    txn.ste_cfg <= ~c;
  endtask
endmodule

// File: tb/partition_id_properties.sv
`timescale 1ns/1ps
module partition_id_checker
  import partition_pkg::*;
#(
  parameter int MAX_PID_NS = 0,
  parameter int MAX_PMG_NS = 0,
  parameter int MAX_PID_S = 0,
  parameter int MAX_PMG_S = 0,
  parameter bit CAP_GLOBAL = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire txn_in_t txn,
  input wire txn_out_t txn_out,
  input wire logic ns_supported,
  input wire logic s_supported
);
  localparam bit NS_SUP = CAP_GLOBAL && (MAX_PID_NS != 0 || MAX_PMG_NS != 0);
  localparam bit S_SUP = CAP_GLOBAL && (MAX_PID_S != 0 || MAX_PMG_S != 0);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  chk_ns_flag: assert property (txn.valid |=> txn_out.ns_flag == !$past(txn.secure))
    else $error("namespace flag wrong");
  chk_idle_ids: assert property (!txn_out.valid |-> txn_out.ids == '0)
    else $error("ids without valid");
  chk_ns_support: assert property (!$past(rst) |-> ns_supported == NS_SUP)
    else $error("ns support wrong");
  chk_s_support: assert property (!$past(rst) |-> s_supported == S_SUP)
    else $error("s support wrong");
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside slot");
  chk_cap_read: assert property (reg_rd && reg_addr == REG_CAP_NS |=>
    reg_rdata == 32'(MAX_PMG_NS << 16 | MAX_PID_NS)) else $error("capability word wrong");
  chk_id3_read: assert property (reg_rd && reg_addr == REG_ID3 |=> reg_rdata[0] == CAP_GLOBAL)
    else $error("global cap bit wrong");
  // Map only on nested, stage-1 control, map present, substream not defaulted
  chk_map_cause: assert property (txn_out.map_used |-> $past(txn.ste_cfg) == CFG_NEST
    && $past(txn.s1_ctrl) && ($past(txn.secure) ? MAX_PID_S : MAX_PID_NS) != 0
    && !($past(txn.s1_dss) == DSS_S2_WHEN_NO_SSID && !$past(txn.has_ssid)))
    else $error("map used wrongly");
  chk_map_kind: assert property (txn.valid && txn.ste_cfg != CFG_NEST |=> !txn_out.map_used)
    else $error("map outside nested");
  cov_map: cover property (txn_out.map_used);
  cov_sec: cover property (txn_out.valid && !txn_out.ns_flag);
  cov_cap: cover property (reg_rd && reg_addr == REG_CAP_S);
endmodule
bind partition_id_assign partition_id_checker #(.MAX_PID_NS(MAX_PID_NS),
  .MAX_PMG_NS(MAX_PMG_NS), .MAX_PID_S(MAX_PID_S), .MAX_PMG_S(MAX_PMG_S),
  .CAP_GLOBAL(CAP_GLOBAL)) partition_id_checker_inst (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .txn(txn), .txn_out(txn_out), .ns_supported(ns_supported),
  .s_supported(s_supported));

// File: tb/partition_id_assign_tb_top.sv
`timescale 1ns/1ps
module partition_id_assign_tb_top
  import partition_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [DATA_W-1:0] reg_rdata;
  txn_in_t txn;
  txn_out_t txn_out;
  logic ns_supported;
  logic s_supported;
  int bad_count = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  partition_id_assign partition_id_assign_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .txn(txn), .txn_out(txn_out), .ns_supported(ns_supported), .s_supported(s_supported));
  client_model client_model_inst (.clk(clk), .txn(txn));
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk(reg_rdata, e);
  endtask
  // Expected {pid, pmg} per source, from the values this bench programs
  function automatic logic [31:0] want(id_src_t e, logic s);
    case (e)
      SRC_GBP: return s ? 32'h0000_0522 : 32'h0012_3411;
      SRC_NSGBP: return 32'h0012_3411;
      SRC_STE: return 32'h0001_0001;
      SRC_CD: return 32'h0000_0302;
      default: return 32'h000a_bc02;
    endcase
  endfunction
  task automatic tx(input logic s, input txn_kind_t k, input logic [2:0] c, input logic m,
    input logic [1:0] d, input logic q, input id_src_t e);
    client_model_inst.send(s, k, c, m, d, q);
    #1;
    chk(32'(txn_out.ids), want(e, s));
    chk(32'(txn_out.ns_flag), 32'(!s));
    chk(32'(txn_out.map_used), 32'(e == SRC_MAP));
    chk(32'(txn_out.valid), 32'h0000_0001);
  endtask
  ////////////////////////////////////////
  initial
  begin
    #50000;
    bad_count++;
    end_sim();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rd(REG_CTRL_NS, 32'h0000_0000); // off at reset
    rd(REG_CAP_NS, 32'h0003_00ff); // limits
    rd(REG_CAP_S, 32'h0001_000f); // secure limits
    rd(REG_ID3, 32'h0000_0001); // cap bit
    rd(REG_STATUS, 32'h0000_0003); // both states
    chk(32'({s_supported, ns_supported}), 32'h0000_0003);
    wr(REG_CAP_NS, 32'hffff_ffff);
    rd(REG_CAP_NS, 32'h0003_00ff); // read only
    wr(8'h40, 32'h1234_5678);
    rd(8'h40, 32'h0000_0000);
    wr(REG_GM_NS, 32'h0044_0077);
    rd(REG_GM_NS, 32'h0044_0077); // kept
    $display("register test done");
    wr(REG_GBP_NS, 32'h0011_1234);
    wr(REG_GBP_S, 32'h0022_0005);
    wr(REG_MAP_BASE + 8'h0c, 32'h0000_0abc);
    tx(1'h0, KIND_NORMAL, CFG_S1, 1'h1, 2'h0, 1'h1, SRC_GBP); // bypass
    tx(1'h1, KIND_NORMAL, CFG_S1, 1'h1, 2'h0, 1'h1, SRC_GBP); // secure set
    $display("bypass test done");
    wr(REG_CTRL_NS, 32'h0000_0001);
    tx(1'h0, KIND_NORMAL, CFG_BYPASS, 1'h1, 2'h0, 1'h1, SRC_STE); // bypass entry
    tx(1'h0, KIND_NORMAL, CFG_S2, 1'h1, 2'h0, 1'h1, SRC_STE); // stage 2
    tx(1'h0, KIND_NORMAL, CFG_S1, 1'h0, 2'h0, 1'h1, SRC_STE); // control off
    tx(1'h0, KIND_NORMAL, CFG_S1, 1'h1, 2'h0, 1'h1, SRC_CD); // descriptor
    tx(1'h0, KIND_NORMAL, CFG_NEST, 1'h0, 2'h0, 1'h1, SRC_STE); // entry
    tx(1'h0, KIND_ATS_REQ, CFG_NEST, 1'h1, 2'h0, 1'h1, SRC_MAP); // mapped
    tx(1'h0, KIND_NORMAL, CFG_NEST, 1'h1, 2'h1, 1'h0, SRC_STE); // no substream
    $display("stream test done");
    tx(1'h0, KIND_ATS_XLATED, CFG_S1, 1'h1, 2'h0, 1'h1, SRC_NSGBP); // check off
    wr(REG_CTRL_NS, 32'h0000_0003);
    tx(1'h0, KIND_ATS_XLATED, CFG_S1, 1'h1, 2'h0, 1'h1, SRC_STE); // entry
    wr(REG_CTRL_NS, 32'h0000_0007);
    tx(1'h0, KIND_ATS_XLATED, CFG_S1, 1'h1, 2'h0, 1'h1, SRC_CD); // with id
    wr(REG_CTRL_S, 32'h0000_0001);
    tx(1'h1, KIND_ATS_XLATED, CFG_S1, 1'h1, 2'h0, 1'h1, SRC_NSGBP); // secure state
    tx(1'h1, KIND_NORMAL, CFG_S2, 1'h1, 2'h0, 1'h1, SRC_STE); // secure entry
    $display("translated test done");
    end_sim();
  end
endmodule
